// [logic/scsr_pkg.sv]
package scsr_pkg;
  // Word width of every transferred value
  localparam int DW = 32;
  // Opcode nibbles: top nibble of the instruction
  localparam logic [3:0] OPC_TO_GPR = 4'h0;
  localparam logic [3:0] OPC_TO_MEM = 4'h4;
  // Opcode nibbles: bottom nibble of the instruction
  localparam logic [3:0] LO_CTRL_GPR = 4'h2;
  localparam logic [3:0] LO_CTRL_MEM = 4'h3;
  localparam logic [3:0] LO_SYS_GPR = 4'ha;
  localparam logic [3:0] LO_SYS_MEM = 4'h2;
  // Middle nibble codes that name a source
  localparam logic [3:0] MID_SW = 4'h0;
  localparam logic [3:0] MID_GB = 4'h1;
  localparam logic [3:0] MID_VB = 4'h2;
  localparam logic [3:0] MID_SS = 4'h3;
  localparam logic [3:0] MID_SPC = 4'h4;
  localparam logic [3:0] MID_MAC_HIGH = 4'h0;
  localparam logic [3:0] MID_MAC_LOW = 4'h1;
  localparam logic [3:0] MID_PR = 4'h2;
  localparam logic [3:0] MID_SGR = 4'h3;
  localparam logic [3:0] MID_DBR = 4'hf;
  // Execution state counts
  localparam logic [1:0] STATES_CTRL = 2'h2;
  localparam logic [1:0] STATES_SGR = 2'h3;
  localparam logic [1:0] STATES_SYS = 2'h1;
  // Pre-decrement step of the push forms
  localparam logic [31:0] PUSH_STEP = 32'h0000_0004;
  // Program counter step on completion
  localparam logic [31:0] PC_STEP = 32'h0000_0002;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0c;
  localparam logic [7:0] OFF_LAST = 8'h10;
  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int NUM_EVT = 6;
  localparam int EVT_GEN_ILL = 0;
  localparam int EVT_SLOT_ILL = 1;
  localparam int EVT_TLB_MISS = 2;
  localparam int EVT_TLB_PROT = 3;
  localparam int EVT_ADDR_ERR = 4;
  localparam int EVT_DONE = 5;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [5:0] MASK_RST = 6'h00;
  // Memory fault codes reported by the load-store side
  localparam logic [1:0] MEM_TLB_MISS = 2'h0;
  localparam logic [1:0] MEM_TLB_PROT = 2'h1;
  localparam logic [1:0] MEM_ADDR_ERR = 2'h2;
  // Source of the stored value
  typedef enum logic [3:0] {
    SRC_SW = 4'h0, SRC_GB = 4'h1, SRC_VB = 4'h2, SRC_SS = 4'h3, SRC_SPC = 4'h4,
    SRC_SGR = 4'h5, SRC_DBR = 4'h6, SRC_BANK = 4'h7, SRC_MAC_HIGH = 4'h8,
    SRC_MAC_LOW = 4'h9, SRC_PR = 4'ha
  } scsr_src_t;
  // Exception codes
  typedef enum logic [2:0] {
    EXC_NONE = 3'h0, EXC_GEN_ILL = 3'h1, EXC_SLOT_ILL = 3'h2,
    EXC_TLB_MISS = 3'h3, EXC_TLB_PROT = 3'h4, EXC_ADDR_ERR = 3'h5
  } scsr_exc_t;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_MEM = 3'b010, ST_EXEC = 3'b100
  } scsr_state_t;
endpackage

// [logic/scsr_dec_if.sv]
interface scsr_dec_if;
  import scsr_pkg::*;
  logic [15:0] code; // Instruction word to decode
  logic hit; // Word is one of the store forms
  logic push; // Memory pre-decrement form
  logic priv; // Form needs privileged mode
  scsr_src_t src; // Selected source
  logic [2:0] bank_idx; // Banked register index
  logic [1:0] states; // Execution states
  modport dec (input code, output hit, push, priv, src, bank_idx, states);
  modport core (output code, input hit, push, priv, src, bank_idx, states);
endinterface

// [logic/scsr_decode.sv]
module scsr_decode (
  scsr_dec_if.dec d
);
  import scsr_pkg::*;
  logic [3:0] hi; // Major opcode
  logic [3:0] mid; // Source field
  logic [3:0] lo; // Minor opcode
  assign hi = d.code[15:12];
  assign mid = d.code[7:4];
  assign lo = d.code[3:0];
  assign d.bank_idx = mid[2:0];

  // Opcode table
  always_comb begin
    d.hit = 1'b0;
    d.push = 1'b0;
    d.src = SRC_SW;
    d.states = STATES_CTRL;
    if ((hi == OPC_TO_GPR && lo == LO_CTRL_GPR) ||
        (hi == OPC_TO_MEM && lo == LO_CTRL_MEM)) begin
      d.push = (hi == OPC_TO_MEM);
      d.hit = 1'b1;
      if (mid[3]) begin
        d.src = SRC_BANK;
      end else if (mid == MID_SW) begin
        d.src = SRC_SW;
      end else if (mid == MID_GB) begin
        d.src = SRC_GB;
      end else if (mid == MID_VB) begin
        d.src = SRC_VB;
      end else if (mid == MID_SS) begin
        d.src = SRC_SS;
      end else if (mid == MID_SPC) begin
        d.src = SRC_SPC;
      end else begin
        d.hit = 1'b0;
      end
    end else if ((hi == OPC_TO_GPR && lo == LO_SYS_GPR) ||
                 (hi == OPC_TO_MEM && lo == LO_SYS_MEM)) begin
      d.push = (hi == OPC_TO_MEM);
      d.hit = 1'b1;
      d.states = STATES_SYS;
      case (mid)
        MID_MAC_HIGH: d.src = SRC_MAC_HIGH;
        MID_MAC_LOW: d.src = SRC_MAC_LOW;
        MID_PR: d.src = SRC_PR;
        MID_SGR: begin
          d.src = SRC_SGR;
          d.states = STATES_SGR;
        end
        MID_DBR: begin
          d.src = SRC_DBR;
          d.states = STATES_CTRL;
        end
        default: d.hit = 1'b0;
      endcase
    end
  end

  // Privilege: all but the global base forms and the mac_high, mac_low and procedure_return forms
  assign d.priv = d.hit && d.src != SRC_GB && d.src != SRC_MAC_HIGH &&
                  d.src != SRC_MAC_LOW && d.src != SRC_PR;
endmodule // scsr_decode

// [logic/scsr_bank_sel.sv]
module scsr_bank_sel #(
  parameter int N = 8,
  parameter int W = 32
) (
  input wire logic [N*W-1:0] bank0,
  input wire logic [N*W-1:0] bank1,
  input wire logic bank_bit,
  input wire logic [$clog2(N)-1:0] idx,
  output logic [W-1:0] data
);
  logic [W-1:0] pick [N]; // Per-entry inactive-bank choice

  // Each entry chooses bank 0 when the bank select bit is set
  for (genvar i = 0; i < N; i++) begin : g_pick
    assign pick[i] = bank_bit ? bank0[i*W +: W] : bank1[i*W +: W];
  end

  assign data = pick[idx];
endmodule // scsr_bank_sel

// [logic/scsr_top.sv]
// What this block does
// - Control register copied to dest_gpr, two states
// - Decode 0000nnnnssss0010 control-to-register forms
// - saved_stack_ptr three states, debug_base two states
// - 1mmm selects inactive-bank register m
// - bank_select_bit one reads bank 0
// - Push: decrement by 4, write word there
// - Decode 0100nnnnssss0011 push forms, two states
// - Push saved_stack_ptr three states, debug_base two
// - Everything privileged except the global_base, mac_high, mac_low and procedure_return forms
// - Privileged form in user mode: general illegal
// - Slot illegal exception for a refused word in a delay slot
// - Push memory faults reported as exceptions
// - System register to dest_gpr, one state
// - System register push, decrement by 4
module scsr_top #(
  parameter int MODE_BIT = 30,
  parameter int BANK_BIT = 29
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic ins_valid,
  output logic ins_ready,
  input wire logic [15:0] ins_code,
  input wire logic ins_in_slot,
  input wire logic [31:0] ins_gpr_value,
  input wire logic [scsr_pkg::DW-1:0] status_word,
  input wire logic [scsr_pkg::DW-1:0] global_base,
  input wire logic [scsr_pkg::DW-1:0] vector_base,
  input wire logic [scsr_pkg::DW-1:0] saved_status,
  input wire logic [scsr_pkg::DW-1:0] saved_pc,
  input wire logic [scsr_pkg::DW-1:0] saved_stack_ptr,
  input wire logic [scsr_pkg::DW-1:0] debug_base,
  input wire logic [scsr_pkg::DW-1:0] mac_high,
  input wire logic [scsr_pkg::DW-1:0] mac_low,
  input wire logic [scsr_pkg::DW-1:0] procedure_return,
  input wire logic [8*scsr_pkg::DW-1:0] bank0_regs,
  input wire logic [8*scsr_pkg::DW-1:0] bank1_regs,
  output logic gpr_we,
  output logic [3:0] gpr_wr_idx,
  output logic [31:0] gpr_wr_data,
  output logic pc_advance,
  output logic exc_valid,
  output scsr_pkg::scsr_exc_t exc_code,
  output logic mem_req,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic mem_err,
  input wire logic [1:0] mem_err_code
);
  import scsr_pkg::*;

  scsr_dec_if dec (); // Decode results
  scsr_state_t state; // Sequencer state
  logic [31:0] ctrl; // Control register
  logic [NUM_EVT-1:0] stat; // Sticky events
  logic [NUM_EVT-1:0] mask; // Event enables
  logic [31:0] done_count; // Completed instructions
  scsr_exc_t last_exc; // Most recent exception
  logic [1:0] cnt; // Remaining states
  logic push_q; // Latched push form
  logic [31:0] src_q; // Latched source value
  logic [31:0] gpr_q; // Latched dest_gpr value
  logic [31:0] bank_val; // Inactive-bank value
  logic [31:0] src_val; // Selected source value
  logic accept; // Instruction taken this cycle
  logic user_mode; // Not privileged
  logic refuse; // Unknown word or privilege refusal
  logic mem_done; // Memory write finished
  logic finish; // Successful completion
  logic [NUM_EVT-1:0] evt; // Event pulses
  logic apb_wr; // Register write strobe
  logic apb_setup; // Setup phase of a transfer

  assign dec.code = ins_code;

  scsr_decode u_dec (
    .d(dec)
  );

  scsr_bank_sel #(
    .N(8),
    .W(DW)
  ) u_bank (
    .bank0(bank0_regs),
    .bank1(bank1_regs),
    .bank_bit(status_word[BANK_BIT]),
    .idx(dec.bank_idx),
    .data(bank_val)
  );

  // Source multiplexer
  always_comb begin
    case (dec.src)
      SRC_SW: src_val = status_word;
      SRC_GB: src_val = global_base;
      SRC_VB: src_val = vector_base;
      SRC_SS: src_val = saved_status;
      SRC_SPC: src_val = saved_pc;
      SRC_SGR: src_val = saved_stack_ptr;
      SRC_DBR: src_val = debug_base;
      SRC_BANK: src_val = bank_val;
      SRC_MAC_HIGH: src_val = mac_high;
      SRC_MAC_LOW: src_val = mac_low;
      SRC_PR: src_val = procedure_return;
      default: src_val = status_word;
    endcase
  end

  // Handshake and checks
  assign ins_ready = (state == ST_IDLE) && ctrl[CTRL_EN_BIT];
  assign accept = ins_valid && ins_ready;
  assign user_mode = !status_word[MODE_BIT];
  assign refuse = !dec.hit || (dec.priv && user_mode);
  assign mem_done = mem_req && mem_ack;
  assign finish = (state == ST_EXEC) && (cnt == 2'h0);

  // Instruction sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      cnt <= 2'h0;
      push_q <= 1'b0;
      src_q <= 32'h0000_0000;
      gpr_q <= 32'h0000_0000;
      gpr_wr_idx <= 4'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (accept && !refuse) begin
            cnt <= dec.states - 2'h1;
            push_q <= dec.push;
            src_q <= src_val;
            gpr_q <= ins_gpr_value;
            gpr_wr_idx <= ins_code[11:8];
            state <= dec.push ? ST_MEM : ST_EXEC;
          end
        end
        ST_MEM: begin
          if (cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
          end
          if (mem_done) begin
            state <= mem_err ? ST_IDLE : ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (cnt == 2'h0) begin
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - 2'h1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Memory write request toward the load-store unit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
    end else if (state == ST_IDLE && accept && !refuse && dec.push) begin
      mem_req <= 1'b1;
      mem_addr <= ins_gpr_value - PUSH_STEP;
      mem_wdata <= src_val;
    end else if (mem_done) begin
      mem_req <= 1'b0;
    end
  end

  // Completion: write dest_gpr and step the pc
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpr_we <= 1'b0;
      gpr_wr_data <= 32'h0000_0000;
      pc_advance <= 1'b0;
    end else begin
      gpr_we <= finish;
      pc_advance <= finish;
      if (finish) begin
        gpr_wr_data <= push_q ? gpr_q - PUSH_STEP : src_q;
      end
    end
  end

  // Exception reporting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc_valid <= 1'b0;
      exc_code <= EXC_NONE;
    end else begin
      exc_valid <= 1'b0;
      if (state == ST_IDLE && accept && refuse) begin
        exc_valid <= 1'b1;
        exc_code <= ins_in_slot ? EXC_SLOT_ILL : EXC_GEN_ILL;
      end else if (mem_done && mem_err) begin
        exc_valid <= 1'b1;
        if (mem_err_code == MEM_TLB_MISS) begin
          exc_code <= EXC_TLB_MISS;
        end else if (mem_err_code == MEM_TLB_PROT) begin
          exc_code <= EXC_TLB_PROT;
        end else begin
          exc_code <= EXC_ADDR_ERR;
        end
      end
    end
  end

  // Event pulses from the registered outputs
  always_comb begin
    evt = '0;
    evt[EVT_GEN_ILL] = exc_valid && exc_code == EXC_GEN_ILL;
    evt[EVT_SLOT_ILL] = exc_valid && exc_code == EXC_SLOT_ILL;
    evt[EVT_TLB_MISS] = exc_valid && exc_code == EXC_TLB_MISS;
    evt[EVT_TLB_PROT] = exc_valid && exc_code == EXC_TLB_PROT;
    evt[EVT_ADDR_ERR] = exc_valid && exc_code == EXC_ADDR_ERR;
    evt[EVT_DONE] = pc_advance;
  end

  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;

  // Control and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
      mask <= MASK_RST;
    end else if (apb_wr) begin
      if (paddr == OFF_CTRL) begin
        ctrl <= {31'h0, pwdata[CTRL_EN_BIT]};
      end else if (paddr == OFF_MASK) begin
        mask <= pwdata[NUM_EVT-1:0];
      end
    end
  end

  // Sticky status: a new event wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat <= '0;
    end else if (apb_wr && paddr == OFF_STAT) begin
      stat <= (stat & ~pwdata[NUM_EVT-1:0]) | evt;
    end else begin
      stat <= stat | evt;
    end
  end

  // Completion counter and last exception
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_count <= 32'h0000_0000;
      last_exc <= EXC_NONE;
    end else begin
      if (pc_advance) begin
        done_count <= done_count + 32'h0000_0001;
      end
      if (exc_valid) begin
        last_exc <= exc_code;
      end
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (paddr == OFF_CTRL) begin
        prdata <= ctrl;
      end else if (paddr == OFF_STAT) begin
        prdata <= {26'h0, stat};
      end else if (paddr == OFF_MASK) begin
        prdata <= {26'h0, mask};
      end else if (paddr == OFF_COUNT) begin
        prdata <= done_count;
      end else if (paddr == OFF_LAST) begin
        prdata <= {29'h0, last_exc};
      end else begin
        pslverr <= 1'b1; // Unmapped address
      end
    end
  end

  assign pready = 1'b1;
  assign irq = |(stat & mask);

  // Checks
  a_push_addr: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(mem_req) |-> mem_addr == $past(ins_gpr_value) - PUSH_STEP &&
    mem_wdata == $past(src_val)) else $error("push address wrong");
  a_user_priv: assert property (@(posedge pclk) disable iff (!presetn)
    accept && dec.hit && dec.priv && user_mode && !ins_in_slot
    |=> exc_valid && exc_code == EXC_GEN_ILL && !mem_req) else $error("no illegal trap");
  a_slot_ill: assert property (@(posedge pclk) disable iff (!presetn)
    accept && refuse && ins_in_slot |=> exc_valid && exc_code == EXC_SLOT_ILL)
    else $error("no slot trap");
  a_gb_free: assert property (@(posedge pclk) disable iff (!presetn)
    accept && dec.hit && dec.src == SRC_GB |=> !exc_valid) else $error("global base trapped");
  a_mem_fault: assert property (@(posedge pclk) disable iff (!presetn)
    mem_done && mem_err |=> exc_valid && exc_code != EXC_NONE && exc_code != EXC_GEN_ILL)
    else $error("fault not reported");
  a_no_commit: assert property (@(posedge pclk) disable iff (!presetn)
    mem_done && mem_err |=> !gpr_we [*2]) else $error("faulted push committed");
  a_sys_one: assert property (@(posedge pclk) disable iff (!presetn)
    accept && !refuse && !dec.push && dec.states == STATES_SYS
    |-> ##2 gpr_we && gpr_wr_data == $past(src_val, 2)) else $error("system copy late");
  a_ctrl_two: assert property (@(posedge pclk) disable iff (!presetn)
    accept && !refuse && !dec.push && dec.states == STATES_CTRL
    |-> !gpr_we ##1 !gpr_we ##1 !gpr_we ##1 gpr_we) else $error("control copy timing");
  a_sgr_three: assert property (@(posedge pclk) disable iff (!presetn)
    accept && !refuse && !dec.push && dec.states == STATES_SGR
    |-> ##4 gpr_we) else $error("stack copy timing");
  a_bank_pick: assert property (@(posedge pclk) disable iff (!presetn)
    dec.src == SRC_BANK && status_word[BANK_BIT]
    |-> src_val == bank0_regs[dec.bank_idx*DW +: DW]) else $error("wrong bank");
  // Bit clear must fall back to the other bank
  a_bank_other: assert property (@(posedge pclk) disable iff (!presetn)
    dec.src == SRC_BANK && !status_word[BANK_BIT]
    |-> src_val == bank1_regs[dec.bank_idx*DW +: DW]) else $error("wrong bank clear");
  a_pc_step: assert property (@(posedge pclk) disable iff (!presetn)
    pc_advance |-> gpr_we && !exc_valid) else $error("pc step without commit");
endmodule // scsr_top

// [testbench/scsr_lsu_model.sv]
module scsr_lsu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic [3:0] delay,
  input wire logic fault,
  input wire logic [1:0] fault_code,
  output logic mem_ack,
  output logic mem_err,
  output logic [1:0] mem_err_code
);
  timeunit 1ns;
  timeprecision 1ns;
  // Stall cycles spent on the current write
  logic [3:0] wait_cnt;
  // Answers a write after the asked stall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_err <= 1'b0;
      mem_err_code <= 2'h0;
      wait_cnt <= 4'h0;
    end else if (mem_req && !mem_ack && wait_cnt == delay) begin
      // Take the word, fault if asked
      mem_ack <= 1'b1;
      mem_err <= fault;
      mem_err_code <= fault_code;
      wait_cnt <= 4'h0;
    end else begin
      // Off the answer cycle the fault lines mean nothing
      mem_ack <= 1'b0;
      mem_err <= ~mem_err;
      mem_err_code <= ~mem_err_code;
      wait_cnt <= (mem_req && !mem_ack) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule // scsr_lsu_model

// [testbench/scsr_top_tb.sv]
module scsr_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import scsr_pkg::*;
  // Status words: privileged bank 1, privileged bank 0, user
  localparam logic [31:0] SW_B1 = 32'h6000_005a;
  localparam logic [31:0] SW_B0 = 32'h4000_005a;
  localparam logic [31:0] SW_USR = 32'h2000_005a;
  // Low bytes of register and push forms, with state counts
  localparam logic [7:0] LO_REG [10] = '{8'h02, 8'h12, 8'h22, 8'h32, 8'h42, 8'h3a, 8'hfa,
    8'h0a, 8'h1a, 8'h2a};
  localparam logic [7:0] LO_MEM [10] = '{8'h03, 8'h13, 8'h23, 8'h33, 8'h43, 8'h32, 8'hf2,
    8'h02, 8'h12, 8'h22};
  localparam int ST [10] = '{2, 2, 2, 2, 2, 3, 2, 1, 1, 1};
  logic pclk, presetn, psel, penable, pwrite, ins_valid, ins_in_slot, fault;
  logic [7:0] paddr;
  logic [15:0] ins_code;
  logic [31:0] pwdata, ins_gpr_value, status_word, prdata, mem_addr, mem_wdata, gpr_wr_data;
  logic [255:0] bank0_regs, bank1_regs;
  logic [31:0] srcv [10]; // Source values, index as in the form tables
  logic [3:0] dly, gpr_wr_idx;
  logic [1:0] fcode, mem_err_code;
  logic pready, pslverr, irq, ins_ready, gpr_we, pc_advance, exc_valid, mem_req, mem_ack;
  logic mem_err;
  scsr_exc_t exc_code;
  int error_cnt, cmp_count, cyc;

  scsr_top u_dut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .irq, .ins_valid, .ins_ready, .ins_code, .ins_in_slot, .ins_gpr_value, .status_word,
    .global_base(srcv[1]), .vector_base(srcv[2]), .saved_status(srcv[3]), .saved_pc(srcv[4]),
    .saved_stack_ptr(srcv[5]), .debug_base(srcv[6]), .mac_high(srcv[7]), .mac_low(srcv[8]),
    .procedure_return(srcv[9]), .bank0_regs, .bank1_regs, .gpr_we, .gpr_wr_idx, .gpr_wr_data,
    .pc_advance, .exc_valid, .exc_code, .mem_req, .mem_addr, .mem_wdata, .mem_ack, .mem_err,
    .mem_err_code
  );
  scsr_lsu_model u_lsu (
    .pclk, .presetn, .mem_req, .delay(dly), .fault, .fault_code(fcode), .mem_ack, .mem_err,
    .mem_err_code
  );

  // Clock, 100 ns period
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      results();
    end
  end

  // Verdict and end of run
  task automatic results();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // One comparison
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One instruction; kind 0 register, 1 push, 2 refused, 3 memory fault
  task automatic run(input logic [15:0] code, input logic [31:0] gpr, input logic [31:0] sw,
      input logic slot, input int s, input int kind, input logic [31:0] expv);
    int ack_k, done_k, want;
    logic saw_req;
    ack_k = 0;
    done_k = 0;
    saw_req = 1'b0;
    @(posedge pclk);
    ins_code <= code;
    ins_gpr_value <= gpr;
    status_word <= sw;
    ins_in_slot <= slot;
    ins_valid <= 1'b1;
    dly <= {2'b00, dly[1:0] + 2'b01};
    do @(negedge pclk); while (ins_ready !== 1'b1);
    @(posedge pclk);
    ins_valid <= 1'b0;
    // Watch cycles after acceptance
    for (int k = 1; k < 60 && done_k == 0; k++) begin
      @(negedge pclk);
      if (mem_ack === 1'b1) ack_k = k;
      if (mem_req === 1'b1) begin
        saw_req = 1'b1;
        chk(mem_addr, gpr - 32'h4);
        chk(mem_wdata, expv);
      end
      if (gpr_we === 1'b1 || exc_valid === 1'b1) done_k = k;
    end
    want = (kind == 0) ? s + 1 : (kind == 2) ? 1 : (kind == 3) ? ack_k + 1 :
      ((s + 1 > ack_k + 2) ? s + 1 : ack_k + 2);
    chk(32'(done_k), 32'(want));
    chk({31'h0, saw_req}, {31'h0, kind == 1 || kind == 3});
    chk({31'h0, gpr_we}, {31'h0, kind < 2});
    if (kind < 2) begin
      chk(gpr_wr_data, kind == 1 ? gpr - 32'h4 : expv);
      chk({28'h0, gpr_wr_idx}, {28'h0, code[11:8]});
      chk({31'h0, pc_advance}, 32'h1);
    end else begin
      chk({29'h0, exc_code}, kind == 3 ? 32'(3 + fcode) : expv);
    end
    // Sources move on so stale values show
    @(posedge pclk);
    foreach (srcv[j]) srcv[j] <= {srcv[j][30:0], srcv[j][31]};
    bank0_regs <= {bank0_regs[254:0], bank0_regs[255]};
    bank1_regs <= {bank1_regs[254:0], bank1_regs[255]};
    // Let the moved sources settle before the caller reads them
    @(negedge pclk);
  endtask

  // Main sequence
  initial begin
    logic [31:0] rd, bv;
    logic [15:0] code;
    logic er;
    int m;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ins_valid = 1'b0;
    ins_in_slot = 1'b0;
    ins_code = 16'h0;
    ins_gpr_value = 32'h0;
    status_word = SW_B1;
    fault = 1'b0;
    fcode = 2'h0;
    dly = 4'h0;
    for (int i = 0; i < 10; i++) srcv[i] = 32'h1111_1111 * 32'(i);
    for (int i = 0; i < 8; i++) begin
      bank0_regs[32*i +: 32] = 32'hb000_0000 | 32'(i);
      bank1_regs[32*i +: 32] = 32'hc000_0000 | 32'(i);
    end
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Register reset values and an unmapped place
    apb(1'b0, OFF_CTRL, 32'h0, rd, er);
    chk(rd, CTRL_RST);
    apb(1'b0, OFF_MASK, 32'h0, rd, er);
    chk(rd, {26'h0, MASK_RST});
    apb(1'b1, 8'h20, 32'hffff_ffff, rd, er);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 8'h20, 32'h0, rd, er);
    chk(rd, 32'h0);
    // Every fixed source, both forms
    for (int i = 0; i < 10; i++) begin
      for (int k = 0; k < 2; k++) begin
        code = {k ? 4'h4 : 4'h0, 4'(i), k ? LO_MEM[i] : LO_REG[i]};
        run(code, 32'h104 * 32'(i), SW_B1, 1'b0, ST[i], k, i ? srcv[i] : SW_B1);
      end
    end
    // Banked sources under both bank bit values
    for (int i = 0; i < 32; i++) begin
      m = i % 8;
      code = {(i % 16) >= 8 ? 4'h4 : 4'h0, 4'(m), 1'b1, 3'(m), (i % 16) >= 8 ? 4'h3 : 4'h2};
      bv = i < 16 ? bank0_regs[32*m +: 32] : bank1_regs[32*m +: 32];
      run(code, 32'h200, i < 16 ? SW_B1 : SW_B0, 1'b0, 2, (i % 16) / 8, bv);
    end
    // User mode, delay slot and unknown words
    run(16'h0102, 32'h40, SW_USR, 1'b0, 2, 2, 32'(EXC_GEN_ILL));
    run(16'h4103, 32'h40, SW_USR, 1'b0, 2, 2, 32'(EXC_GEN_ILL));
    run(16'h0112, 32'h40, SW_USR, 1'b0, 2, 0, srcv[1]);
    run(16'h4113, 32'h40, SW_USR, 1'b0, 2, 1, srcv[1]);
    run(16'h0102, 32'h40, SW_USR, 1'b1, 2, 2, 32'(EXC_SLOT_ILL));
    run(16'hffff, 32'h40, SW_B1, 1'b0, 1, 2, 32'(EXC_GEN_ILL));
    // Each memory fault on a push
    for (int i = 0; i < 3; i++) begin
      @(posedge pclk);
      fault <= 1'b1;
      fcode <= 2'(i);
      run(16'h4613, 32'h80, SW_B1, 1'b0, 2, 3, srcv[1]);
    end
    @(posedge pclk);
    fault <= 1'b0;
    // Events, mask, interrupt and clear
    apb(1'b0, OFF_STAT, 32'h0, rd, er);
    chk(rd, 32'h3f);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, OFF_MASK, 32'h1 << EVT_SLOT_ILL, rd, er);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, OFF_STAT, 32'h3f, rd, er);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, OFF_LAST, 32'h0, rd, er);
    chk(rd, 32'(EXC_ADDR_ERR));
    // Completed instructions so far: 20 fixed, 32 banked, 2 user mode
    apb(1'b0, OFF_COUNT, 32'h0, rd, er);
    chk(rd, 32'h36);
    // Disabled block refuses work
    apb(1'b1, OFF_CTRL, 32'h0, rd, er);
    @(negedge pclk);
    chk({31'h0, ins_ready}, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h1, rd, er);
    run(16'h052a, 32'h0, SW_B1, 1'b0, 1, 0, srcv[9]);
    results();
  end
endmodule // scsr_top_tb
